/* File: rtg_rate_gen.sv */
// Rate timer with its registers behind an AXI4-Lite slave
// Assumes a receiver and transmitter on the same clock that
// supply the idle and shift-empty flags and consume bit_tick
`timescale 1ns/1ps
`default_nettype none
`include "rtg_regs.svh"

module rtg_rate_gen
    import rtg_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]    s_axi_awprot,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic [2:0]    s_axi_arprot,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          rx_idle,
    input  wire logic          tx_shift_empty,
    output logic               port_enable,
    output logic               sync_mode,
    output logic               bit_tick
);

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Register storage
    logic [7:0]    rc_q;
    logic [7:0]    rc_d;
    logic [7:0]    lo_q;
    logic [7:0]    lo_d;
    logic [7:0]    hi_q;
    logic [7:0]    hi_d;
    logic [7:0]    ts_q;
    logic [7:0]    ts_d;
    logic [7:0]    pc_q;
    logic [7:0]    pc_d;

    // Write channel state
    rtg_wr_t       wr_q;
    rtg_wr_t       wr_d;
    logic [AW-1:0] awaddr_q;
    logic [AW-1:0] awaddr_d;
    logic [31:0]   wdata_q;
    logic [31:0]   wdata_d;
    logic [3:0]    wstrb_q;
    logic [3:0]    wstrb_d;
    logic [1:0]    bresp_q;
    logic [1:0]    bresp_d;

    // Read channel state
    logic          rvalid_q;
    logic          rvalid_d;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;
    logic [1:0]    rresp_q;
    logic [1:0]    rresp_d;

    // Write decode
    logic          aw_fire;
    logic          w_fire;
    logic          do_write;
    logic [AW-1:0] wa;
    logic [31:0]   wd;
    logic [3:0]    ws;
    logic          wa_hit;
    logic          div_write;

    // Timer side
    logic          wide;
    logic          high_speed;
    rtg_mul_t      mul_sel;
    logic          pre_tick;
    logic          timer_clear;
    logic          wrap;
    logic [15:0]   count;

    // Read decode
    logic [7:0]    rd_byte;
    logic          rd_hit;
    logic          ar_fire;

    // Handshake outputs
    assign s_axi_awready = (wr_q == RTG_WR_IDLE) || (wr_q == RTG_WR_DATA);
    assign s_axi_wready  = (wr_q == RTG_WR_IDLE) || (wr_q == RTG_WR_ADDR);
    assign s_axi_bvalid  = (wr_q == RTG_WR_RESP);
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire  = s_axi_wvalid && s_axi_wready;
    assign ar_fire = s_axi_arvalid && s_axi_arready;

    // A write completes once both address and data are held
    assign do_write = (aw_fire || wr_q == RTG_WR_ADDR)
                   && (w_fire || wr_q == RTG_WR_DATA)
                   && (wr_q != RTG_WR_RESP);
    assign wa = aw_fire ? s_axi_awaddr : awaddr_q;
    assign wd = w_fire ? s_axi_wdata : wdata_q;
    assign ws = w_fire ? s_axi_wstrb : wstrb_q;

    // Mapped offsets
    always_comb begin
        case (wa)
            `RTG_OFF_RATE_CTRL,
            `RTG_OFF_DIV_LOW,
            `RTG_OFF_DIV_HIGH,
            `RTG_OFF_TX_CTRL,
            `RTG_OFF_PORT_CTRL,
            `RTG_OFF_STATUS:    wa_hit = 1'b1;
            default:            wa_hit = 1'b0;
        endcase
    end

    // Write channel sequencer; address and data in either order
    always_comb begin
        wr_d     = wr_q;
        awaddr_d = aw_fire ? s_axi_awaddr : awaddr_q;
        wdata_d  = w_fire ? s_axi_wdata : wdata_q;
        wstrb_d  = w_fire ? s_axi_wstrb : wstrb_q;
        bresp_d  = bresp_q;
        case (wr_q)
            RTG_WR_IDLE: begin
                if (do_write) begin
                    wr_d = RTG_WR_RESP;
                end else if (aw_fire) begin
                    wr_d = RTG_WR_ADDR;
                end else if (w_fire) begin
                    wr_d = RTG_WR_DATA;
                end
            end
            RTG_WR_ADDR: begin
                if (do_write) begin
                    wr_d = RTG_WR_RESP;
                end
            end
            RTG_WR_DATA: begin
                if (do_write) begin
                    wr_d = RTG_WR_RESP;
                end
            end
            RTG_WR_RESP: begin
                if (s_axi_bready) begin
                    wr_d = RTG_WR_IDLE;
                end
            end
            default: wr_d = RTG_WR_IDLE;
        endcase
        if (do_write) begin
            bresp_d = wa_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Register writes; only byte lane 0 carries data
    always_comb begin
        rc_d = rc_q;
        lo_d = lo_q;
        hi_d = hi_q;
        ts_d = ts_q;
        pc_d = pc_q;
        if (do_write && ws[0]) begin
            case (wa)
                `RTG_OFF_RATE_CTRL: rc_d = wd[7:0] & `RTG_RC_WMASK;
                `RTG_OFF_DIV_LOW:   lo_d = wd[7:0];
                `RTG_OFF_DIV_HIGH:  hi_d = wd[7:0];
                `RTG_OFF_TX_CTRL:   ts_d = wd[7:0] & `RTG_TS_WMASK;
                `RTG_OFF_PORT_CTRL: pc_d = wd[7:0];
                default:            rc_d = rc_q;
            endcase
        end
    end

    // Either divisor byte written restarts the count
    assign div_write = do_write && ws[0]
                    && (wa == `RTG_OFF_DIV_LOW || wa == `RTG_OFF_DIV_HIGH);

    // Mode bits that steer the timer
    assign wide        = rc_q[`RTG_RC_WIDE_BIT];
    assign high_speed  = ts_q[`RTG_TS_HSPD_BIT];
    assign sync_mode   = ts_q[`RTG_TS_SYNC_BIT];
    assign port_enable = pc_q[`RTG_PC_EN_BIT];

    // Period multiplier from mode, speed and width
    always_comb begin
        if (sync_mode) begin
            mul_sel = RTG_MUL_4;
        end else begin
            case ({wide, high_speed})
                2'b00:   mul_sel = RTG_MUL_64;
                2'b01:   mul_sel = RTG_MUL_16;
                2'b10:   mul_sel = RTG_MUL_16;
                2'b11:   mul_sel = RTG_MUL_4;
                default: mul_sel = RTG_MUL_64;
            endcase
        end
    end

    // Disabled port holds the timer in reset
    assign timer_clear = div_write || !port_enable;

    // Clock prescaler ahead of the divisor counter
    rtg_prescale u_pre (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .clear   (timer_clear),
        .mul_sel (mul_sel),
        .tick    (pre_tick)
    );

    // Free running divisor counter, period n+1 steps
    rtg_timer #(
        .W (16)
    ) u_timer (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .clear   (timer_clear),
        .step    (pre_tick),
        .wide    (wide),
        .div     ({hi_q, lo_q}),
        .wrap_q  (wrap),
        .count_q (count)
    );

    // One pulse per bit period, registered in the timer
    assign bit_tick = wrap;

    // Read data for the offered address
    always_comb begin
        rd_byte = `RTG_RST_BYTE;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `RTG_OFF_RATE_CTRL: begin
                rd_byte = rc_q;
                rd_byte[`RTG_RC_IDLE_BIT] = rx_idle;
            end
            `RTG_OFF_DIV_LOW:   rd_byte = lo_q;
            `RTG_OFF_DIV_HIGH:  rd_byte = hi_q;
            `RTG_OFF_TX_CTRL: begin
                rd_byte = ts_q;
                rd_byte[`RTG_TS_EMPTY_BIT] = tx_shift_empty;
            end
            `RTG_OFF_PORT_CTRL: rd_byte = pc_q;
            `RTG_OFF_STATUS:    rd_byte = 8'h00;
            default:            rd_hit  = 1'b0;
        endcase
    end

    // Read channel; status word returns the live count
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (ar_fire) begin
            rvalid_d = 1'b1;
            rresp_d  = rd_hit ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_araddr == `RTG_OFF_STATUS) begin
                rdata_d = {16'h0000, count};
            end else begin
                rdata_d = {24'h000000, rd_byte};
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // Register update
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_q     <= RTG_WR_IDLE;
            awaddr_q <= '0;
            wdata_q  <= 32'h00000000;
            wstrb_q  <= 4'h0;
            bresp_q  <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= RESP_OKAY;
            rc_q     <= `RTG_RST_BYTE;
            lo_q     <= `RTG_RST_BYTE;
            hi_q     <= `RTG_RST_BYTE;
            ts_q     <= `RTG_RST_BYTE;
            pc_q     <= `RTG_RST_BYTE;
        end else begin
            wr_q     <= wr_d;
            awaddr_q <= awaddr_d;
            wdata_q  <= wdata_d;
            wstrb_q  <= wstrb_d;
            bresp_q  <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
            rc_q     <= rc_d;
            lo_q     <= lo_d;
            hi_q     <= hi_d;
            ts_q     <= ts_d;
            pc_q     <= pc_d;
        end
    end

endmodule
`default_nettype wire

/* File: rtg_regs.svh */
// Register map, field positions, reset values and timing counts
// Included by the rate timer files; holds definitions only
`ifndef RTG_REGS_SVH
`define RTG_REGS_SVH

// Byte offsets on the register bus
`define RTG_OFF_RATE_CTRL   8'h00
`define RTG_OFF_DIV_LOW     8'h04
`define RTG_OFF_DIV_HIGH    8'h08
`define RTG_OFF_TX_CTRL     8'h0C
`define RTG_OFF_PORT_CTRL   8'h10
`define RTG_OFF_STATUS      8'h14

// Field positions in rate_control_reg
`define RTG_RC_IDLE_BIT     3'd6
`define RTG_RC_WIDE_BIT     3'd3
`define RTG_RC_WMASK        8'h1B

// Field positions in transmit_status_control
`define RTG_TS_SYNC_BIT     3'd4
`define RTG_TS_HSPD_BIT     3'd2
`define RTG_TS_EMPTY_BIT    3'd1
`define RTG_TS_WMASK        8'hFD

// Field positions in the port control register
`define RTG_PC_EN_BIT       3'd7

// Reset values
`define RTG_RST_BYTE        8'h00

// Prescaler terminal counts for the x4, x16 and x64 multipliers
`define RTG_PRE_4           6'd3
`define RTG_PRE_16          6'd15
`define RTG_PRE_64          6'd63

`endif

/* File: rtg_pkg.sv */
// Types shared by the rate timer design files
// Assumes rtg_regs.svh supplies the numeric constants
package rtg_pkg;

    // Period multiplier applied in front of the divisor
    typedef enum logic [1:0] {
        RTG_MUL_4  = 2'b00,
        RTG_MUL_16 = 2'b01,
        RTG_MUL_64 = 2'b10
    } rtg_mul_t;

    // Write channel sequencer of the bus slave
    typedef enum logic [1:0] {
        RTG_WR_IDLE = 2'b00,
        RTG_WR_ADDR = 2'b01,
        RTG_WR_DATA = 2'b10,
        RTG_WR_RESP = 2'b11
    } rtg_wr_t;

endpackage

/* File: rtg_prescale.sv */
// Prescaler that divides the system clock by 4, 16 or 64
// Assumes the caller clears it whenever the divisor is rewritten
`timescale 1ns/1ps
`default_nettype none
`include "rtg_regs.svh"

module rtg_prescale
    import rtg_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire logic     nrst,
    input  wire logic     clear,
    input  wire rtg_mul_t mul_sel,
    output logic          tick
);

    logic [5:0] pre_q;
    logic [5:0] pre_d;
    logic [5:0] last;

    // Terminal count of the selected multiplier
    always_comb begin
        case (mul_sel)
            RTG_MUL_4:  last = `RTG_PRE_4;
            RTG_MUL_16: last = `RTG_PRE_16;
            RTG_MUL_64: last = `RTG_PRE_64;
            default:    last = `RTG_PRE_64;
        endcase
    end

    // Free running count; a shrunk multiplier wraps at once
    assign tick = !clear && (pre_q >= last);

    always_comb begin
        if (clear || pre_q >= last) begin
            pre_d = 6'h00;
        end else begin
            pre_d = pre_q + 6'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pre_q <= 6'h00;
        end else begin
            pre_q <= pre_d;
        end
    end

endmodule
`default_nettype wire

/* File: rtg_timer.sv */
// Divisor counter, 8 or 16 bits wide, stepped by the prescaler
// Assumes a clear pulse on every divisor write or port disable
`timescale 1ns/1ps
`default_nettype none

module rtg_timer #(
    parameter int W = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic         clear,
    input  wire logic         step,
    input  wire logic         wide,
    input  wire logic [W-1:0] div,
    output logic              wrap_q,
    output logic [W-1:0]      count_q
);

    logic [W-1:0] count_d;
    logic [W-1:0] limit;
    logic         wrap_d;

    // Narrow mode uses the low byte only
    assign limit = wide ? div : {{(W-8){1'b0}}, div[7:0]};

    // Count 0..n, one bit period per wrap
    always_comb begin
        count_d = count_q;
        wrap_d  = 1'b0;
        if (clear) begin
            count_d = '0;
        end else if (step) begin
            if (count_q >= limit) begin
                count_d = '0;
                wrap_d  = 1'b1;
            end else begin
                count_d = count_q + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count_q <= '0;
            wrap_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            wrap_q  <= wrap_d;
        end
    end

endmodule
`default_nettype wire

/* File: rtg_rate_gen_assertions.sv */
// Concurrent checks on the rate timer bus slave and bit tick
// Bound to rtg_rate_gen; sees only its ports
`timescale 1ns/1ps
`default_nettype none

module rtg_rate_gen_chk #(
    parameter int AW = 8
) (
    input wire logic          clk_sys,
    input wire logic          nrst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic          s_axi_awvalid,
    input wire logic          s_axi_awready,
    input wire logic [3:0]    s_axi_wstrb,
    input wire logic          s_axi_wvalid,
    input wire logic          s_axi_wready,
    input wire logic [1:0]    s_axi_bresp,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic [31:0]   s_axi_rdata,
    input wire logic          s_axi_rvalid,
    input wire logic          s_axi_rready,
    input wire logic          port_enable,
    input wire logic          bit_tick
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Both halves of a write taken at one edge
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Read address taken
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Quiet tick for two cycles
    sequence s_quiet2;
        !bit_tick [*2];
    endsequence

    property p_wr_answer;
        s_wr_both |=> s_axi_bvalid;
    endproperty
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_wr_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_rd_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    property p_tick_pulse;
        bit_tick |=> !bit_tick [*3];
    endproperty
    property p_tick_off;
        !port_enable ##1 !port_enable |-> !bit_tick;
    endproperty
    // Only a write that carries byte lane 0 reaches the divisor
    property p_div_clear;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_wstrb[0] && s_axi_awaddr == 8'h04 |=> ##1 s_quiet2;
    endproperty

    a_wr_answer:  assert property (p_wr_answer)
        else $error("write not answered");
    a_rd_answer:  assert property (p_rd_answer)
        else $error("read not answered");
    a_b_hold:     assert property (p_b_hold)
        else $error("write response dropped early");
    a_r_hold:     assert property (p_r_hold)
        else $error("read data dropped early");
    a_wr_block:   assert property (p_wr_block)
        else $error("write taken while response pending");
    a_rd_block:   assert property (p_rd_block)
        else $error("read taken while data pending");
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("bit tick too close");
    a_tick_off:   assert property (p_tick_off)
        else $error("bit tick while disabled");
    a_div_clear:  assert property (p_div_clear)
        else $error("divisor write did not clear timer");
endmodule

bind rtg_rate_gen rtg_rate_gen_chk #(.AW(AW)) u_rtg_rate_gen_chk (
    .clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .port_enable, .bit_tick
);

`default_nettype wire

/* File: tb_rtg_rate_gen.sv */
// Self-checking bench for the rate timer block
// Drives the register bus and receiver flags, times bit_tick
`timescale 1ns/1ps
`default_nettype none

module tb_rtg_rate_gen;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [2:0]  s_axi_awprot = 3'h0;
    logic [2:0]  s_axi_arprot = 3'h0;
    logic [1:0]  s_axi_bresp;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b1;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic        rx_idle = 1'b1;
    logic        tx_shift_empty = 1'b1;
    logic        port_enable, sync_mode, bit_tick;
    int          num_errors = 0;
    int          checks_done = 0;
    int          c;

    // Mode table: rate control, tx control, low, high, period
    localparam logic [7:0] RC [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
    localparam logic [7:0] TX [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h14, 8'h10};
    localparam logic [7:0] LO [6] = '{8'h02, 8'h03, 8'h02, 8'h05, 8'h05, 8'h07};
    localparam logic [7:0] HI [6] = '{8'h05, 8'h05, 8'h01, 8'h01, 8'h05, 8'h01};
    localparam int         PE [6] = '{192, 64, 4144, 1048, 24, 1056};

    rtg_rate_gen u_rtg_rate_gen (
        .clk_sys, .nrst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rx_idle, .tx_shift_empty, .port_enable, .sync_mode, .bit_tick
    );

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bus write; response ready stays high, answer taken when seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (pa && s_axi_awready === 1'b1) begin
                pa = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (pw && s_axi_wready === 1'b1) begin
                pw = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (pa || pw);
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    // Bus read; data ready stays high, data taken at the answer edge
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // Cycles between two bit ticks
    task automatic per(input int e);
        int n;
        n = 0;
        do @(posedge clk_sys); while (bit_tick !== 1'b1);
        do begin
            @(posedge clk_sys);
            n++;
        end while (bit_tick !== 1'b1);
        chk("period", e, n);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        conclude();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(8'h00, 32'h40, 2'b00);
        rd(8'h0C, 32'h02, 2'b00);
        rd(8'h10, 32'h00, 2'b00);
        wr(8'h00, 32'hFF, 2'b00);
        rd(8'h00, 32'h5B, 2'b00);
        rx_idle <= 1'b0;
        rd(8'h00, 32'h1B, 2'b00);
        wr(8'h20, 32'h01, 2'b10);
        rd(8'h20, 32'h00, 2'b10);
        s_axi_wstrb <= 4'hE;
        wr(8'h04, 32'hAA, 2'b00);
        s_axi_wstrb <= 4'hF;
        rd(8'h04, 32'h00, 2'b00);
        rd(8'h14, 32'h00, 2'b00);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            wr(8'h10, 32'h00, 2'b00);
            wr(8'h00, {24'h0, RC[i]}, 2'b00);
            wr(8'h0C, {24'h0, TX[i]}, 2'b00);
            wr(8'h04, {24'h0, LO[i]}, 2'b00);
            wr(8'h08, {24'h0, HI[i]}, 2'b00);
            wr(8'h10, 32'h80, 2'b00);
            chk("port_enable", 32'h1, {31'h0, port_enable});
            chk("sync_mode", {31'h0, TX[i][4]}, {31'h0, sync_mode});
            per(PE[i]);
        end
        $display("test rates done");
        wr(8'h10, 32'h00, 2'b00);
        wr(8'h00, 32'h00, 2'b00);
        wr(8'h0C, 32'h00, 2'b00);
        wr(8'h08, 32'h00, 2'b00);
        wr(8'h04, 32'hC8, 2'b00);
        wr(8'h10, 32'h80, 2'b00);
        do @(posedge clk_sys); while (bit_tick !== 1'b1);
        repeat (100) @(posedge clk_sys);
        wr(8'h04, 32'h00, 2'b00);
        c = 0;
        do begin
            @(posedge clk_sys);
            c++;
        end while (bit_tick !== 1'b1 && c < 300);
        chk("clear_gap", 32'h40, c);
        $display("test divisor clear done");
        conclude();
    end
endmodule

`default_nettype wire
